// >>> src/aom_pkg.sv
package aom_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] SEL_OFS      = 8'h00;
  localparam logic [7:0] UPPER_OFS    = 8'h04;
  localparam logic [7:0] LOWER_OFS    = 8'h08;
  localparam logic [7:0] QUAL_OFS     = 8'h0C;
  localparam logic [7:0] ODLY_OFS     = 8'h10;
  localparam logic [7:0] START_OFS    = 8'h14;
  localparam logic [7:0] STATUS_OFS   = 8'h18;
  localparam logic [7:0] IRQ_OFS      = 8'h1C;
  localparam logic [7:0] MASK_OFS     = 8'h20;
  localparam logic [7:0] DOFUNC_OFS   = 8'h24;

  // ==========================================================================
  // selection digits, one nibble each (bcd)
  localparam int UNITS_POS    = 0;
  localparam int TENS_POS     = 4;
  localparam int HUND_POS     = 8;
  localparam int THOU_POS     = 12;
  localparam int TENK_POS     = 16;
  localparam logic [19:0] SEL_RESET = 20'h1_1100;
  localparam logic [19:0] SEL_MAX   = 20'h1_1133;

  // ==========================================================================
  // reset values, times in units of 10 ms
  localparam logic [15:0] UPPER_RESET = 16'hFFFF;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] QUAL_RESET  = 16'h0000;
  localparam logic [15:0] ODLY_RESET  = 16'h0000;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [15:0] TIME_MAX    = 16'h1388;
  localparam logic [15:0] ODLY_MAX    = 16'h2710;
  localparam logic [7:0]  DOFUNC_OVERLIMIT = 8'h1B;
  localparam logic [7:0]  DOFUNC_RESET     = 8'h00;

  // ==========================================================================
  // timing
  localparam int CLK_HZ     = 10_000_000;
  localparam int TICK_MS    = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ==========================================================================
  // stop actions and sources
  typedef enum logic [1:0]
  {
    STOP_COAST = 2'b00,
    STOP_EMERG = 2'b01,
    STOP_DECEL = 2'b10,
    STOP_NONE  = 2'b11
  } aom_stop_t;

  typedef enum logic [1:0]
  {
    SRC_NONE  = 2'b00,
    SRC_PANEL = 2'b01,
    SRC_AIN1  = 2'b10,
    SRC_AIN2  = 2'b11
  } aom_src_t;

  typedef enum logic [1:0]
  {
    ST_START  = 2'b00,
    ST_WATCH  = 2'b01,
    ST_QUAL   = 2'b10,
    ST_OVER   = 2'b11
  } aom_state_t;

endpackage

// >>> src/aom_timer_if.sv
`timescale 1ns/1ps
interface aom_timer_if;
  logic        load;
  logic [15:0] count;
  logic        done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// >>> src/aom_timer.sv
`timescale 1ns/1ps
// counts 10 ms ticks; done once count ticks have passed since load fell
module aom_timer
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire logic     tick,
  // control
  aom_timer_if.timer    tmr
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (tmr.load)
      cnt_next = 16'h0000;
    else if (tick && cnt_reg < tmr.count)
      cnt_next = cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_next;
  end

  assign tmr.done = !tmr.load && (cnt_reg >= tmr.count);

endmodule

// >>> src/aom_monitor.sv
`timescale 1ns/1ps
// Operation
// - units digit picks action: coast, emergency stop, decelerate, none.
// - tens digit picks source: none, panel pot, input one, input two.
// - hundreds digit 0 checks always, 1 only while run command active.
// - ten-thousands digit 1 raises external fault on over-limit.
// - thousands digit is ignored.
// - out of limit when above upper or below lower; drives output.
// - output terminal assigned to over-limit by function code 27.
// - selection accepts 00000..11133, resets to 11100.
// - qualification time settable 0.00..50.00.
// - output delay before terminal turns on, settable up to 100.
// - start-of-detection time settable 0.00..50.00.
module aom_monitor
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog samples and run command
  input  wire logic [15:0] panelValue,
  input  wire logic [15:0] analogInputOne,
  input  wire logic [15:0] analogInputTwo,
  input  wire logic        runCmd,
  // drive actions
  output logic             overlimitOut,
  output logic             stopReq,
  output logic [1:0]       stopMode,
  output logic             extFault,
  output logic             irq
);

  // ==========================================================================
  // input synchroniser
  logic [1:0] runSync1_reg;
  logic       runSync_reg;
  logic       runActive;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      runSync1_reg <= 2'b00;
      runSync_reg  <= 1'b0;
    end
    else
    begin
      runSync1_reg <= {runSync1_reg[0], runCmd};
      runSync_reg  <= runSync1_reg[1];
    end
  end
  assign runActive = runSync_reg;

  // ==========================================================================
  // registers
  logic [19:0] sel_reg,    sel_next;
  logic [15:0] upper_reg,  upper_next;
  logic [15:0] lower_reg,  lower_next;
  logic [15:0] qual_reg,   qual_next;
  logic [15:0] odly_reg,   odly_next;
  logic [15:0] start_reg,  start_next;
  logic [7:0]  dofunc_reg, dofunc_next;
  logic [1:0]  irq_reg,    irq_next;
  logic [1:0]  mask_reg,   mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        wrEn;
  logic        rdEn;
  logic        badAddr;
  logic [1:0]  events;
  aom_pkg::aom_state_t state_reg, state_next;

  assign wrEn   = psel && penable && pwrite;
  assign rdEn   = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    case (paddr)
      aom_pkg::SEL_OFS, aom_pkg::UPPER_OFS, aom_pkg::LOWER_OFS, aom_pkg::QUAL_OFS,
      aom_pkg::ODLY_OFS, aom_pkg::START_OFS, aom_pkg::STATUS_OFS, aom_pkg::IRQ_OFS,
      aom_pkg::MASK_OFS, aom_pkg::DOFUNC_OFS: badAddr = 1'b0;
      default: badAddr = 1'b1;
    endcase
  end
  assign pslverr = psel && penable && badAddr;

  function automatic logic selValid(input logic [19:0] v);
    logic ok;
    ok = (v[19:16] <= 4'h1) && (v[15:12] <= 4'h1) && (v[11:8] <= 4'h1)
      && (v[7:4] <= 4'h3) && (v[3:0] <= 4'h3);
    return ok;
  endfunction

  always_comb
  begin
    sel_next    = sel_reg;
    upper_next  = upper_reg;
    lower_next  = lower_reg;
    qual_next   = qual_reg;
    odly_next   = odly_reg;
    start_next  = start_reg;
    dofunc_next = dofunc_reg;
    mask_next   = mask_reg;
    irq_next    = irq_reg;
    prdata_next = prdata_reg;
    if (wrEn)
    begin
      case (paddr)
        aom_pkg::SEL_OFS:
          if (selValid(pwdata[19:0]))
            sel_next = pwdata[19:0];
        aom_pkg::UPPER_OFS:  upper_next = pwdata[15:0];
        aom_pkg::LOWER_OFS:  lower_next = pwdata[15:0];
        aom_pkg::QUAL_OFS:
          if (pwdata[15:0] <= aom_pkg::TIME_MAX)
            qual_next = pwdata[15:0];
        aom_pkg::ODLY_OFS:
          if (pwdata[15:0] <= aom_pkg::ODLY_MAX)
            odly_next = pwdata[15:0];
        aom_pkg::START_OFS:
          if (pwdata[15:0] <= aom_pkg::TIME_MAX)
            start_next = pwdata[15:0];
        aom_pkg::IRQ_OFS:    irq_next = irq_reg & ~pwdata[1:0];
        aom_pkg::MASK_OFS:   mask_next = pwdata[1:0];
        aom_pkg::DOFUNC_OFS: dofunc_next = pwdata[7:0];
        default: ;
      endcase
    end
    irq_next = irq_next | events;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        aom_pkg::SEL_OFS:    prdata_next = {12'h000, sel_reg};
        aom_pkg::UPPER_OFS:  prdata_next = {16'h0000, upper_reg};
        aom_pkg::LOWER_OFS:  prdata_next = {16'h0000, lower_reg};
        aom_pkg::QUAL_OFS:   prdata_next = {16'h0000, qual_reg};
        aom_pkg::ODLY_OFS:   prdata_next = {16'h0000, odly_reg};
        aom_pkg::START_OFS:  prdata_next = {16'h0000, start_reg};
        aom_pkg::STATUS_OFS: prdata_next = {27'h000_0000, extFault, stopReq, overlimitOut, state_reg};
        aom_pkg::IRQ_OFS:    prdata_next = {30'h0000_0000, irq_reg};
        aom_pkg::MASK_OFS:   prdata_next = {30'h0000_0000, mask_reg};
        aom_pkg::DOFUNC_OFS: prdata_next = {24'h00_0000, dofunc_reg};
        default:             prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sel_reg    <= aom_pkg::SEL_RESET;
      upper_reg  <= aom_pkg::UPPER_RESET;
      lower_reg  <= aom_pkg::LOWER_RESET;
      qual_reg   <= aom_pkg::QUAL_RESET;
      odly_reg   <= aom_pkg::ODLY_RESET;
      start_reg  <= aom_pkg::START_RESET;
      dofunc_reg <= aom_pkg::DOFUNC_RESET;
      mask_reg   <= 2'b00;
      irq_reg    <= 2'b00;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      sel_reg    <= sel_next;
      upper_reg  <= upper_next;
      lower_reg  <= lower_next;
      qual_reg   <= qual_next;
      odly_reg   <= odly_next;
      start_reg  <= start_next;
      dofunc_reg <= dofunc_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      prdata_reg <= prdata_next;
    end
  end
  assign prdata = prdata_reg;
  assign irq    = |(irq_reg & mask_reg);

  // ==========================================================================
  // selection decode
  aom_pkg::aom_stop_t stopSel;
  aom_pkg::aom_src_t  srcSel;
  logic               runOnly;
  logic               faultEn;
  logic [15:0]        sample;
  logic               outOfBand;
  logic               checkOn;
  assign stopSel = aom_pkg::aom_stop_t'(sel_reg[aom_pkg::UNITS_POS +: 2]);
  assign srcSel  = aom_pkg::aom_src_t'(sel_reg[aom_pkg::TENS_POS +: 2]);
  assign runOnly = sel_reg[aom_pkg::HUND_POS];
  assign faultEn = sel_reg[aom_pkg::TENK_POS];
  // thousands digit is never read

  always_comb
  begin
    unique case (srcSel)
      aom_pkg::SRC_NONE:  sample = 16'h0000;
      aom_pkg::SRC_PANEL: sample = panelValue;
      aom_pkg::SRC_AIN1:  sample = analogInputOne;
      aom_pkg::SRC_AIN2:  sample = analogInputTwo;
    endcase
  end
  assign outOfBand = (sample > upper_reg) || (sample < lower_reg);
  assign checkOn   = (srcSel != aom_pkg::SRC_NONE) && (!runOnly || runActive);

  // ==========================================================================
  // 10 ms tick and timers
  logic [19:0] tick_reg, tick_next;
  logic        tick;
  assign tick = (tick_reg == 20'(aom_pkg::TICK_CYCLES - 1));
  always_comb
  begin
    tick_next = tick ? 20'h0_0000 : tick_reg + 20'h0_0001;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tick_reg <= 20'h0_0000;
    else
      tick_reg <= tick_next;
  end

  aom_timer_if tStart ();
  aom_timer_if tQual ();
  aom_timer_if tOut ();
  aom_timer uStart (.clk(clk), .sys_rst(sys_rst), .tick(tick), .tmr(tStart));
  aom_timer uQual  (.clk(clk), .sys_rst(sys_rst), .tick(tick), .tmr(tQual));
  aom_timer uOut   (.clk(clk), .sys_rst(sys_rst), .tick(tick), .tmr(tOut));

  // ==========================================================================
  // detection state machine
  logic overState;
  logic outLvl_reg, outLvl_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      aom_pkg::ST_START:
        if (!checkOn)
          state_next = aom_pkg::ST_START;
        else if (tStart.done)
          state_next = aom_pkg::ST_WATCH;
      aom_pkg::ST_WATCH:
        if (!checkOn)
          state_next = aom_pkg::ST_START;
        else if (outOfBand)
          state_next = aom_pkg::ST_QUAL;
      aom_pkg::ST_QUAL:
        if (!checkOn)
          state_next = aom_pkg::ST_START;
        else if (!outOfBand)
          state_next = aom_pkg::ST_WATCH;
        else if (tQual.done)
          state_next = aom_pkg::ST_OVER;
      aom_pkg::ST_OVER:
        if (!checkOn)
          state_next = aom_pkg::ST_START;
        else if (!outOfBand)
          state_next = aom_pkg::ST_WATCH;
    endcase
  end
  assign tStart.load = (state_reg != aom_pkg::ST_START) || !checkOn;
  assign tStart.count = start_reg;
  assign tQual.load  = (state_reg != aom_pkg::ST_QUAL);
  assign tQual.count = qual_reg;
  assign overState   = (state_reg == aom_pkg::ST_OVER) && checkOn;
  // output terminal turns on after the delay, turns off as soon as over-limit clears
  assign tOut.load   = (overState == outLvl_reg);
  assign tOut.count  = odly_reg;
  assign outLvl_next = tOut.done ? overState : outLvl_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg  <= aom_pkg::ST_START;
      outLvl_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      outLvl_reg <= outLvl_next;
    end
  end

  // ==========================================================================
  // actions
  logic stop_reg, stop_next;
  logic fault_reg, fault_next;
  logic dout_reg, dout_next;
  logic [1:0] mode_reg, mode_next;
  always_comb
  begin
    stop_next  = overState && (stopSel != aom_pkg::STOP_NONE);
    mode_next  = stopSel;
    fault_next = overState && faultEn;
    dout_next  = outLvl_reg && overState && (dofunc_reg == aom_pkg::DOFUNC_OVERLIMIT);
    events     = {fault_next && !fault_reg, (state_next == aom_pkg::ST_OVER)
                  && (state_reg != aom_pkg::ST_OVER)};
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stop_reg  <= 1'b0;
      fault_reg <= 1'b0;
      dout_reg  <= 1'b0;
      mode_reg  <= 2'b11;
    end
    else
    begin
      stop_reg  <= stop_next;
      fault_reg <= fault_next;
      dout_reg  <= dout_next;
      mode_reg  <= mode_next;
    end
  end
  assign stopReq      = stop_reg;
  assign stopMode     = mode_reg;
  assign extFault     = fault_reg;
  assign overlimitOut = dout_reg;

endmodule

// >>> verification/aom_chk_monitor.sv
`timescale 1ns/1ps
module aom_chk
(
  // clock, reset, apb
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // samples and actions
  input wire logic [15:0] panelValue,
  input wire logic [15:0] analogInputOne,
  input wire logic [15:0] analogInputTwo,
  input wire logic        runCmd,
  input wire logic        overlimitOut,
  input wire logic        stopReq,
  input wire logic [1:0]  stopMode,
  input wire logic        extFault
);
  // ========
  // register mirrors
  logic [19:0] sel_reg;
  logic [19:0] sel_next;
  logic [15:0] hi_reg;
  logic [15:0] hi_next;
  logic [15:0] lo_reg;
  logic [15:0] lo_next;
  logic [7:0]  fn_reg;
  logic [7:0]  fn_next;
  logic        wr;
  logic        oob;
  logic [15:0] smp;
  always_comb
  begin
    wr = psel && penable && pwrite && pready;
    sel_next = sel_reg;
    hi_next = wr && paddr == aom_pkg::UPPER_OFS ? pwdata[15:0] : hi_reg;
    lo_next = wr && paddr == aom_pkg::LOWER_OFS ? pwdata[15:0] : lo_reg;
    fn_next = wr && paddr == aom_pkg::DOFUNC_OFS ? pwdata[7:0] : fn_reg;
    if (wr && paddr == aom_pkg::SEL_OFS && pwdata[19:16] < 4'h2 && pwdata[15:12] < 4'h2
        && pwdata[11:8] < 4'h2 && pwdata[7:4] < 4'h4 && pwdata[3:0] < 4'h4)
      sel_next = pwdata[19:0];
    smp = sel_reg[5:4] == 2'h1 ? panelValue : sel_reg[5:4] == 2'h2 ? analogInputOne : analogInputTwo;
    oob = sel_reg[5:4] != 2'h0 && (smp > hi_reg || smp < lo_reg);
  end
  always_ff @(posedge clk)
  begin
    sel_reg <= sys_rst ? aom_pkg::SEL_RESET : sel_next;
    hi_reg  <= sys_rst ? aom_pkg::UPPER_RESET : hi_next;
    lo_reg  <= sys_rst ? aom_pkg::LOWER_RESET : lo_next;
    fn_reg  <= sys_rst ? aom_pkg::DOFUNC_RESET : fn_next;
  end
  // ========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sRunLow;
    !runCmd [*8];
  endsequence
  AST_STOP_MODE: assert property (stopReq |-> stopMode == $past(sel_reg[1:0]) && stopMode != 2'h3)
    else $error("stop mode does not match units digit");
  AST_NONE_QUIET: assert property (sel_reg[5:4] == 2'h0 && $past(sel_reg[5:4], 2) == 2'h0
    |-> !stopReq && !extFault) else $error("action with no source selected");
  AST_FAULT_ENABLED: assert property (extFault |-> $past(sel_reg[16]))
    else $error("fault without alarm digit");
  AST_FAULT_WITH_STOP: assert property (extFault |-> stopReq || $past(sel_reg[1:0]) == 2'h3)
    else $error("fault without over-limit");
  AST_TERM_FUNC: assert property (overlimitOut |-> $past(fn_reg) == aom_pkg::DOFUNC_OVERLIMIT)
    else $error("terminal active without function code");
  AST_OOB_HELD: assert property ($rose(stopReq) |-> $past(oob, 2) && $past(oob, 3))
    else $error("over-limit without out-of-band input");
  AST_RUN_GATE: assert property (sRunLow ##0 (sel_reg[8] && $stable(sel_reg)) |-> !$rose(stopReq))
    else $error("over-limit without run command");
  AST_TERM_SRC: assert property ($rose(overlimitOut) |-> $past(sel_reg[5:4]) != 2'h0)
    else $error("terminal active with no source");
endmodule

bind aom_monitor aom_chk u_chk
(
  .clk, .sys_rst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .panelValue,
  .analogInputOne, .analogInputTwo, .runCmd, .overlimitOut, .stopReq, .stopMode, .extFault
);

// >>> verification/aom_src_model.sv
`timescale 1ns/1ps
module aom_src_model
(
  // control
  input wire logic        clk,
  input wire logic [1:0]  hotSel,
  input wire logic        goHigh,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  // samples
  output logic     [15:0] panelValue,
  output logic     [15:0] analogInputOne,
  output logic     [15:0] analogInputTwo
);
  // ========
  // in-band value wobbles, hot source sits one step outside
  logic [3:0]  wob = 4'h0;
  logic [15:0] mid;
  logic [15:0] bad;
  always_comb
  begin
    mid = lower + ((upper - lower) >> 1) + {12'h000, wob};
    bad = goHigh ? upper + 16'h0001 : lower - 16'h0001;
  end
  always_ff @(posedge clk)
  begin
    wob            <= wob + 4'h1;
    panelValue     <= hotSel == 2'h1 ? bad : mid;
    analogInputOne <= hotSel == 2'h2 ? bad : mid;
    analogInputTwo <= hotSel == 2'h3 ? bad : mid;
  end
endmodule

// >>> verification/aom_monitor_bench.sv
`timescale 1ns/1ps
module aom_monitor_bench;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        runCmd;
  logic        overlimitOut;
  logic        stopReq;
  logic [1:0]  stopMode;
  logic        extFault;
  logic        irq;
  logic [1:0]  hotSel;
  logic        goHigh;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] panelValue;
  logic [15:0] analogInputOne;
  logic [15:0] analogInputTwo;
  logic [31:0] rd;
  logic        err;
  logic [19:0] s;
  logic [1:0]  hot;
  logic [31:0] rnd;
  logic [4:0]  e;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          seed = 32'hc9b6;
  logic [15:0] tabW = 16'hFF80;
  logic [7:0]  tabA [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24, 8'h00,
                            8'h00, 8'h00, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h14, 8'h14};
  logic [19:0] tabD [16] = '{20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h1_1134,
                            20'h0_1133, 20'h1_1143, 20'h1389, 20'h1388, 20'h2711, 20'h2710, 20'h1389, 20'h1388};
  logic [19:0] tabE [16] = '{20'h1_1100, 20'hFFFF, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h1_1100,
                            20'h0_1133, 20'h0_1133, 20'h0, 20'h1388, 20'h0, 20'h2710, 20'h0, 20'h1388};

  aom_monitor dut
  (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .panelValue,
    .analogInputOne, .analogInputTwo, .runCmd, .overlimitOut, .stopReq, .stopMode, .extFault, .irq
  );
  aom_src_model u_src
  (
    .clk, .hotSel, .goHigh, .upper, .lower, .panelValue, .analogInputOne, .analogInputTwo
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ========
  // checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [4:0] expect_out(input logic [19:0] sl, input logic [1:0] h, input logic [31:0] x);
    logic act;
    act = sl[5:4] != 2'h0 && sl[5:4] == h && (!sl[8] || x[0]);
    return {act && sl[1:0] != 2'h3, act && sl[16], act && x[1], act && x[2], act};
  endfunction

  task automatic give_verdict;
    $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // ========
  // main sequence
  initial
  begin
    {psel, penable, pwrite, runCmd, goHigh} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hotSel = 2'h0;
    upper = 16'hC000;
    lower = 16'h1000;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      if (tabW[i])
        apb(1'b1, tabA[i], 32'(tabD[i]));
      apb(1'b0, tabA[i], 32'h0000_0000);
      chk(rd, 32'(tabE[i]));
    end
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    for (int i = 0; i < 64; i++)
    begin
      rnd = $random(seed);
      s = {3'h0, i[5], 3'h0, rnd[4], 3'h0, i[4], 2'h0, i[3:2], 2'h0, i[1:0]};
      hot = rnd[3] ? i[3:2] : rnd[6:5];
      sys_rst <= 1'b1;
      hotSel <= 2'h0;
      goHigh <= rnd[31];
      runCmd <= rnd[0];
      upper <= 16'hC000 + 16'(rnd[12:0]);
      lower <= 16'h1000 + 16'(rnd[28:16]);
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      apb(1'b1, 8'h00, 32'(s));
      apb(1'b1, 8'h04, 32'(upper));
      apb(1'b1, 8'h08, 32'(lower));
      apb(1'b1, 8'h24, rnd[1] ? 32'h0000_001B : 32'h0000_001A);
      apb(1'b1, 8'h20, {30'h0000_0000, rnd[2], rnd[2]});
      hotSel <= hot;
      repeat (10) @(posedge clk);
      e = expect_out(s, hot, rnd);
      chk(32'(stopReq), 32'(e[4]));
      chk(32'(extFault), 32'(e[3]));
      chk(32'(overlimitOut), 32'(e[2]));
      chk(32'(irq), 32'(e[1]));
      if (e[0])
        chk(32'(stopMode), 32'(s[1:0]));
      apb(1'b1, 8'h1C, 32'h0000_0003);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk(rd, {27'h000_0000, e[3], e[4], e[2], e[0] ? 2'h3 : {1'b0, s[5:4] != 2'h0 && (!s[8] || rnd[0])}});
    end
    give_verdict();
  end
endmodule
